/* ccs_pkg.sv */
// package: constants, types and register map of the complement / compare-skip execute block
package ccs_pkg;
    // opcode matching
    localparam logic [5:0] OPC_COMPLEMENT = 6'h07;
    localparam logic [6:0] OPC_COMPARE_SKIP = 7'h31;
    localparam int DEST_BIT = 9;
    localparam int BANK_ACCESS_BIT = 8;
    localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

    // apb register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BANK_SEL = 8'h04;
    localparam logic [7:0] ADDR_WORK = 8'h08;
    localparam logic [7:0] ADDR_INDEX_BASE = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // values after reset
    localparam logic RST_EXT_EN = 1'b0;
    localparam logic [3:0] RST_BANK_SEL = 4'h0;
    localparam logic [7:0] RST_WORK = 8'h00;
    localparam logic [11:0] RST_INDEX_BASE = 12'h000;

    typedef enum logic [1:0] {
        CCS_FETCH = 2'b00,
        CCS_EXEC = 2'b01,
        CCS_SKIP = 2'b10,
        CCS_SKIP2 = 2'b11
    } ccs_state_t;

    typedef struct packed {
        logic we;
        logic [11:0] addr;
        logic [7:0] wdata;
    } ccs_mem_req_t;
endpackage

/* ccs_exec.sv */
// file: execute logic for the complement and compare-skip-equal instructions, with apb control
//
// Contract
// - complement opcode reads the addressed data byte and inverts every bit.
// - destination bit zero writes the complement into the working register only.
// - destination bit one writes the complement back to the same data address.
// - bank access bit zero uses access bank; one uses the bank select register.
// - access bit zero, extended set on, address up to 95: indexed literal offset.
// - compare opcode subtracts working register from data byte, keeping the difference only in the status register.
// - equal compare discards the fetched next instruction as a no-operation.
// - skipping a two-word instruction makes the compare three instruction cycles.
module ccs_exec (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // instruction fetch
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic instr_two_word,
    output logic instr_ready,
    // data memory
    output ccs_pkg::ccs_mem_req_t mem_req,
    input wire logic [7:0] mem_rdata,
    // execution events
    output logic skip_taken,
    output logic nop_executed
);
    ccs_pkg::ccs_state_t state_reg, state_next;
    logic ext_en_reg, ext_en_next;
    logic [3:0] bank_sel_reg, bank_sel_next;
    logic [7:0] work_reg, work_next;
    logic [11:0] index_base_reg, index_base_next;
    logic is_compare_reg, is_compare_next;
    logic dest_file_reg, dest_file_next;
    logic indexed_reg, indexed_next;
    logic [11:0] addr_reg, addr_next;
    ccs_pkg::ccs_mem_req_t req_reg, req_next;
    logic skip_reg, skip_next;
    logic nop_reg, nop_next;
    logic [7:0] diff_reg, diff_next;

    logic is_complement, is_compare, access_bit, accept, apb_write;
    logic [7:0] f_field, complement_val;
    logic [11:0] decoded_addr;

    assign f_field = instr_word[7:0];
    assign access_bit = instr_word[ccs_pkg::BANK_ACCESS_BIT];
    assign is_complement = (instr_word[15:10] == ccs_pkg::OPC_COMPLEMENT);
    assign is_compare = (instr_word[15:9] == ccs_pkg::OPC_COMPARE_SKIP);
    assign instr_ready = (state_reg != ccs_pkg::CCS_EXEC);
    assign accept = instr_valid && instr_ready;
    assign complement_val = ~mem_rdata;
    assign apb_write = psel && penable && pwrite;

    // address selection for either opcode
    always_comb begin
        if (!access_bit && ext_en_reg && f_field <= ccs_pkg::INDEXED_LIMIT) begin
            decoded_addr = index_base_reg + {4'h0, f_field};
        end else if (!access_bit) begin
            decoded_addr = {(f_field > ccs_pkg::INDEXED_LIMIT) ? ccs_pkg::ACCESS_HIGH_BANK
                            : ccs_pkg::ACCESS_LOW_BANK, f_field};
        end else begin
            decoded_addr = {bank_sel_reg, f_field};
        end
    end

    // instruction sequencing
    always_comb begin
        state_next = state_reg;
        is_compare_next = is_compare_reg;
        dest_file_next = dest_file_reg;
        indexed_next = indexed_reg;
        addr_next = addr_reg;
        req_next = '0;
        req_next.addr = addr_reg;
        skip_next = 1'b0;
        nop_next = 1'b0;
        diff_next = diff_reg;
        unique case (state_reg)
            ccs_pkg::CCS_FETCH: begin
                // other opcodes belong to other execute units and are passed over here
                if (accept && (is_complement || is_compare)) begin
                    state_next = ccs_pkg::CCS_EXEC;
                    is_compare_next = is_compare;
                    dest_file_next = instr_word[ccs_pkg::DEST_BIT];
                    indexed_next = !access_bit && ext_en_reg && f_field <= ccs_pkg::INDEXED_LIMIT;
                    addr_next = decoded_addr;
                    req_next.addr = decoded_addr;
                end
            end
            ccs_pkg::CCS_EXEC: begin
                if (is_compare_reg) begin
                    diff_next = mem_rdata - work_reg;
                    if (mem_rdata == work_reg) begin
                        state_next = ccs_pkg::CCS_SKIP;
                        skip_next = 1'b1;
                    end else begin
                        state_next = ccs_pkg::CCS_FETCH;
                    end
                end else begin
                    state_next = ccs_pkg::CCS_FETCH;
                    if (dest_file_reg) begin
                        req_next.we = 1'b1;
                        req_next.wdata = complement_val;
                    end
                end
            end
            ccs_pkg::CCS_SKIP: begin
                if (accept) begin
                    nop_next = 1'b1;
                    state_next = instr_two_word ? ccs_pkg::CCS_SKIP2 : ccs_pkg::CCS_FETCH;
                end
            end
            ccs_pkg::CCS_SKIP2: begin
                if (accept) begin
                    nop_next = 1'b1;
                    state_next = ccs_pkg::CCS_FETCH;
                end
            end
        endcase
    end

    // software-visible registers; the hardware result wins over a same-cycle software write
    always_comb begin
        ext_en_next = ext_en_reg;
        bank_sel_next = bank_sel_reg;
        work_next = work_reg;
        index_base_next = index_base_reg;
        if (apb_write) begin
            unique case (paddr)
                ccs_pkg::ADDR_CTRL: ext_en_next = pwdata[0];
                ccs_pkg::ADDR_BANK_SEL: bank_sel_next = pwdata[3:0];
                ccs_pkg::ADDR_WORK: work_next = pwdata[7:0];
                ccs_pkg::ADDR_INDEX_BASE: index_base_next = pwdata[11:0];
                default: ;
            endcase
        end
        if (state_reg == ccs_pkg::CCS_EXEC && !is_compare_reg && !dest_file_reg) begin
            work_next = complement_val;
        end
    end

    // apb read side answers at once; unmapped addresses flag an error
    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        pready = 1'b1;
        unique case (paddr)
            ccs_pkg::ADDR_CTRL: prdata = {31'h0000_0000, ext_en_reg};
            ccs_pkg::ADDR_BANK_SEL: prdata = {28'h000_0000, bank_sel_reg};
            ccs_pkg::ADDR_WORK: prdata = {24'h00_0000, work_reg};
            ccs_pkg::ADDR_INDEX_BASE: prdata = {20'h0_0000, index_base_reg};
            ccs_pkg::ADDR_STATUS: prdata = {8'h00, diff_reg, 4'h0, addr_reg[11:8],
                                            addr_reg[7:0] & 8'hFF} & 32'h00FF_0FFF
                                           | {28'h000_0000, indexed_reg, 1'b0, state_reg} << 12;
            default: pslverr = psel && penable;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ccs_pkg::CCS_FETCH;
            is_compare_reg <= 1'b0;
            dest_file_reg <= 1'b0;
            indexed_reg <= 1'b0;
            addr_reg <= 12'h000;
            req_reg <= '0;
            skip_reg <= 1'b0;
            nop_reg <= 1'b0;
            diff_reg <= 8'h00;
            ext_en_reg <= ccs_pkg::RST_EXT_EN;
            bank_sel_reg <= ccs_pkg::RST_BANK_SEL;
            work_reg <= ccs_pkg::RST_WORK;
            index_base_reg <= ccs_pkg::RST_INDEX_BASE;
        end else begin
            state_reg <= state_next;
            is_compare_reg <= is_compare_next;
            dest_file_reg <= dest_file_next;
            indexed_reg <= indexed_next;
            addr_reg <= addr_next;
            req_reg <= req_next;
            skip_reg <= skip_next;
            nop_reg <= nop_next;
            diff_reg <= diff_next;
            ext_en_reg <= ext_en_next;
            bank_sel_reg <= bank_sel_next;
            work_reg <= work_next;
            index_base_reg <= index_base_next;
        end
    end

    assign mem_req = req_reg;
    assign skip_taken = skip_reg;
    assign nop_executed = nop_reg;
endmodule

/* ccs_exec_chk.sv */
// checker: port properties of the complement / compare-skip execute block
module ccs_exec_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // fetch, memory and events
    input wire logic instr_valid, instr_two_word, instr_ready,
    input wire logic [15:0] instr_word,
    input wire ccs_pkg::ccs_mem_req_t mem_req,
    input wire logic [7:0] mem_rdata,
    input wire logic skip_taken, nop_executed
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = instr_valid && instr_ready;
    wire is_com = instr_word[15:10] == ccs_pkg::OPC_COMPLEMENT;
    wire is_cmp = instr_word[15:9] == ccs_pkg::OPC_COMPARE_SKIP;
    sequence s_com; acc && is_com; endsequence
    sequence s_cmp; acc && is_cmp; endsequence
    // a word taken in the cycle of the skip pulse is the discarded one
    sequence s_drop; skip_taken && acc; endsequence
    AST_ONE_CYCLE: assert property (acc && (is_com || is_cmp) |=> !instr_ready ##1 instr_ready)
        else $error("execute cycle count wrong");
    AST_WRITEBACK: assert property (s_com ##0 instr_word[9] |-> ##2 mem_req.we && mem_req.wdata == ~$past(mem_rdata))
        else $error("complement write-back wrong");
    AST_TO_WORK: assert property (s_com ##0 !instr_word[9] |-> ##2 !mem_req.we)
        else $error("memory written for work destination");
    AST_HIGH_BANK: assert property (acc && (is_com || is_cmp) && !instr_word[8]
        && instr_word[7:0] > ccs_pkg::INDEXED_LIMIT
        |=> mem_req.addr == {ccs_pkg::ACCESS_HIGH_BANK, $past(instr_word[7:0])})
        else $error("access bank address wrong");
    AST_SAME_ADDR: assert property (mem_req.we |-> $stable(mem_req.addr))
        else $error("write-back address moved");
    AST_NO_STORE: assert property (s_cmp |=> !mem_req.we [*2])
        else $error("compare wrote memory");
    AST_NOP: assert property (s_drop |=> nop_executed)
        else $error("discarded word not reported");
    AST_TWO_WORD: assert property (s_drop ##0 instr_two_word ##1 acc |=> nop_executed)
        else $error("second word not discarded");
endmodule
bind ccs_exec ccs_exec_chk u_chk (.*);

/* ccs_mem_model.sv */
// data memory model answering the execute block's operand requests
module ccs_mem_model (
    // clock
    input wire logic pclk,
    // request and read data
    input wire ccs_pkg::ccs_mem_req_t mem_req,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [4096];
    // pattern keeps every byte distinct from its complement
    initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'hA5;
    assign mem_rdata = mem[mem_req.addr];
    always @(posedge pclk) if (mem_req.we) mem[mem_req.addr] <= mem_req.wdata;
endmodule

/* ccs_exec_tb.sv */
// self-checking bench for the complement / compare-skip execute block
module ccs_exec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
    logic instr_valid, instr_two_word, instr_ready, skip_taken, nop_executed;
    logic [7:0] paddr, mem_rdata;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] instr_word;
    ccs_pkg::ccs_mem_req_t mem_req;
    int err_count = 0, n_checks = 0, nskip = 0, nnop = 0;
    ccs_exec dut (.*);
    ccs_mem_model u_mem (.*);
    initial begin
        pclk = 0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        nskip += int'(skip_taken);
        nnop += int'(nop_executed);
    end
    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one idle cycle after each transfer avoids two psel writes in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, wr, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        se = pslverr;
        {psel, penable} <= 2'h0;
        @(posedge pclk);
    endtask
    task automatic issue(input logic [15:0] w, input logic tw);
        {instr_valid, instr_word, instr_two_word} <= {1'h1, w, tw};
        forever begin
            @(negedge pclk);
            if (instr_ready === 1'h1) break;
            @(posedge pclk);
        end
        @(posedge pclk);
    endtask
    task automatic idle();
        instr_valid <= 1'h0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        results();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {instr_valid, instr_word, instr_two_word} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        for (int a = 0; a < 16; a += 4) begin
            apb(1'h0, 8'(a), 32'h0);
            chk("reset", rd, 32'h0);
        end
        apb(1'h1, ccs_pkg::ADDR_BANK_SEL, 32'hFFFFFFF3);
        apb(1'h0, ccs_pkg::ADDR_BANK_SEL, 32'h0);
        chk("bank", rd, 32'h3);
        apb(1'h0, 8'h14, 32'h0);
        chk("slverr", 32'(se), 32'h1);
        $display("registers done");
        issue(16'h1C13, 1'h0);
        idle();
        apb(1'h0, ccs_pkg::ADDR_WORK, 32'h0);
        chk("work", rd, 32'h49);
        chk("source", 32'(u_mem.mem[12'h013]), 32'hB6);
        issue(16'h1F80, 1'h0);
        issue(16'h1E80, 1'h0);
        idle();
        chk("mem 380", 32'(u_mem.mem[12'h380]), 32'hDA);
        chk("mem F80", 32'(u_mem.mem[12'hF80]), 32'hDA);
        apb(1'h1, ccs_pkg::ADDR_CTRL, 32'h1);
        apb(1'h1, ccs_pkg::ADDR_INDEX_BASE, 32'h200);
        issue(16'h1E10, 1'h0);
        idle();
        chk("mem 210", 32'(u_mem.mem[12'h210]), 32'h4A);
        $display("complement done");
        apb(1'h1, ccs_pkg::ADDR_WORK, 32'hDA);
        issue(16'h6380, 1'h0);
        issue(16'h0000, 1'h1);
        issue(16'h0000, 1'h0);
        idle();
        chk("skips", 32'(nskip), 32'h1);
        chk("drops", 32'(nnop), 32'h2);
        chk("no store", 32'(u_mem.mem[12'h380]), 32'hDA);
        issue(16'h6220, 1'h0);
        issue(16'h0000, 1'h0);
        idle();
        apb(1'h0, ccs_pkg::ADDR_STATUS, 32'h0);
        chk("status", rd, 32'h00AB8220);
        apb(1'h1, ccs_pkg::ADDR_WORK, 32'h85);
        issue(16'h6220, 1'h0);
        issue(16'h0000, 1'h0);
        idle();
        chk("skips", 32'(nskip), 32'h2);
        chk("drops", 32'(nnop), 32'h3);
        $display("compare done");
        results();
    end
endmodule
